// File: rtl/scp_readout.sv
`timescale 1ns/1ns
`default_nettype none
`include "scp_defs.svh"
module scp_readout #(
	parameter int AW        = 20,                 // address width
	parameter int PULSE_CYC = `SCP_PULSE_CYC      // reload pulse length
) (
	input  wire logic               clk_sys,          // system clock
	input  wire logic               rstn,             // sync reset, active low
	input  wire scp_pkg::scp_cfg_s  cfg_pins,         // cclk, reset_oe, ce_n
	input  wire scp_pkg::scp_jtag_s jtag_pins,        // tck, tms, tdi
	output logic                    serial_data_line_o,  // data out value
	output logic                    serial_data_line_oe_n, // low drives
	output logic                    cascade_enable_out_n, // cascade enable
	output logic                    fpga_reload_pulse_n_o, // reload value
	output logic                    fpga_reload_pulse_n_oe_n, // low drives
	output logic                    tdo,              // scan data out
	output logic                    standby,          // low-power state
	output logic [AW-1:0]           mem_addr,         // storage address
	input  wire logic               mem_bit           // stored bit at addr
);
	import scp_pkg::*;
	initial begin
		if (AW < 2 || AW > 24 || PULSE_CYC < 1)
			$error("unsupported parameter values");
	end
	function automatic logic agree(input logic [2:0] s);
		return s[2] == s[1];
	endfunction
	// three-stage synchronisers; change counts when stages two and three agree
	logic [2:0] s_cclk_ff, s_oe_ff, s_ce_ff, s_tck_ff, s_tms_ff, s_tdi_ff;
	logic       cclk_ff, oe_ff, ce_n_ff, tck_ff, tms_ff, tdi_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_cclk_ff <= 3'h0;
			s_oe_ff   <= 3'h0;
			s_ce_ff   <= 3'h7;
			s_tck_ff  <= 3'h0;
			s_tms_ff  <= 3'h7;
			s_tdi_ff  <= 3'h7;
		end else begin
			s_cclk_ff <= {s_cclk_ff[1:0], cfg_pins.cclk};
			s_oe_ff   <= {s_oe_ff[1:0], cfg_pins.reset_oe};
			s_ce_ff   <= {s_ce_ff[1:0], cfg_pins.ce_n};
			s_tck_ff  <= {s_tck_ff[1:0], jtag_pins.tck};
			s_tms_ff  <= {s_tms_ff[1:0], jtag_pins.tms};
			s_tdi_ff  <= {s_tdi_ff[1:0], jtag_pins.tdi};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cclk_ff <= 1'b0;
			oe_ff   <= 1'b0;
			ce_n_ff <= 1'b1;
			tck_ff  <= 1'b0;
			tms_ff  <= 1'b1;
			tdi_ff  <= 1'b1;
		end else begin
			if (agree(s_cclk_ff)) cclk_ff <= s_cclk_ff[2];
			if (agree(s_oe_ff))   oe_ff   <= s_oe_ff[2];
			if (agree(s_ce_ff))   ce_n_ff <= s_ce_ff[2];
			if (agree(s_tck_ff))  tck_ff  <= s_tck_ff[2];
			if (agree(s_tms_ff))  tms_ff  <= s_tms_ff[2];
			if (agree(s_tdi_ff))  tdi_ff  <= s_tdi_ff[2];
		end
	end
	logic cclk_rise, tck_rise, tck_fall;
	assign cclk_rise = agree(s_cclk_ff) && s_cclk_ff[2] && !cclk_ff;
	assign tck_rise  = agree(s_tck_ff) && s_tck_ff[2] && !tck_ff;
	assign tck_fall  = agree(s_tck_ff) && !s_tck_ff[2] && tck_ff;

	// read-out counters
	logic [AW-1:0] addr_ff;
	logic          last_ff;   // all data clocked out
	logic          cas_ff;    // cascade active (low output)
	logic          lock_ff;   // high until read again
	logic          advance;
	assign advance = cclk_rise && !ce_n_ff && oe_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn || !oe_ff) begin
			addr_ff <= '0;
			last_ff <= 1'b0;
		end else if (advance && !last_ff) begin
			if (addr_ff == {AW{1'b1}})
				last_ff <= 1'b1;
			else
				addr_ff <= addr_ff + 1'b1;
		end
	end
	assign mem_addr = addr_ff;

	// buffer between storage and pin: each new address pushes its bit,
	// each counted edge pops the bit that was on the pin
	logic fifo_ready, fifo_valid, fifo_bit, fifo_pop, want_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn || !oe_ff)
			want_ff <= 1'b1;
		else if (advance && !last_ff && addr_ff != {AW{1'b1}})
			want_ff <= 1'b1;
		else if (fifo_ready)
			want_ff <= 1'b0;
	end
	assign fifo_pop = advance && !last_ff && fifo_valid;
	scp_fifo #(.WIDTH(1), .DEPTH(`SCP_FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.flush     (!oe_ff),
		.in_valid  (want_ff && oe_ff),
		.in_ready  (fifo_ready),
		.in_data   (mem_bit),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_bit)
	);
	logic dat_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			dat_ff <= 1'b1;
		else if (fifo_valid)
			dat_ff <= fifo_bit;
	end
	assign serial_data_line_o = dat_ff;

	// cascade output
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cas_ff  <= 1'b0;
			lock_ff <= 1'b0;
		end else if (last_ff && !lock_ff) begin
			cas_ff <= 1'b1;
			if (!oe_ff)
				lock_ff <= 1'b1;
		end else if (lock_ff && addr_ff == {AW{1'b1}} && advance) begin
			lock_ff <= 1'b0;
		end else begin
			cas_ff <= 1'b0;
		end
	end
	assign cascade_enable_out_n = !(cas_ff && !lock_ff && !ce_n_ff);

	// test access port
	scp_tap_e            tap_ff;
	scp_tap_e            nxt_tap;
	logic [`SCP_IR_W-1:0] ir_sh_ff, ir_ff;
	logic                 byp_ff, tdo_ff;
	always_comb begin
		nxt_tap = tap_ff;
		case (tap_ff)
		TAP_RESET:  nxt_tap = tms_ff ? TAP_RESET : TAP_IDLE;
		TAP_IDLE:   nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
		TAP_SEL_DR: nxt_tap = tms_ff ? TAP_SEL_IR : TAP_CAP_DR;
		TAP_CAP_DR: nxt_tap = tms_ff ? TAP_EX1_DR : TAP_SH_DR;
		TAP_SH_DR:  nxt_tap = tms_ff ? TAP_EX1_DR : TAP_SH_DR;
		TAP_EX1_DR: nxt_tap = tms_ff ? TAP_UPD_DR : TAP_PAU_DR;
		TAP_PAU_DR: nxt_tap = tms_ff ? TAP_EX2_DR : TAP_PAU_DR;
		TAP_EX2_DR: nxt_tap = tms_ff ? TAP_UPD_DR : TAP_SH_DR;
		TAP_UPD_DR: nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
		TAP_SEL_IR: nxt_tap = tms_ff ? TAP_RESET : TAP_CAP_IR;
		TAP_CAP_IR: nxt_tap = tms_ff ? TAP_EX1_IR : TAP_SH_IR;
		TAP_SH_IR:  nxt_tap = tms_ff ? TAP_EX1_IR : TAP_SH_IR;
		TAP_EX1_IR: nxt_tap = tms_ff ? TAP_UPD_IR : TAP_PAU_IR;
		TAP_PAU_IR: nxt_tap = tms_ff ? TAP_EX2_IR : TAP_PAU_IR;
		TAP_EX2_IR: nxt_tap = tms_ff ? TAP_UPD_IR : TAP_SH_IR;
		TAP_UPD_IR: nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
		default:    nxt_tap = TAP_RESET;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			tap_ff <= TAP_RESET;
		else if (tck_rise)
			tap_ff <= nxt_tap;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ir_sh_ff <= '0;
			ir_ff    <= `SCP_IR_BYPASS;
			byp_ff   <= 1'b0;
		end else if (tck_rise) begin
			if (tap_ff == TAP_CAP_IR)
				ir_sh_ff <= `SCP_IR_RESET;
			else if (tap_ff == TAP_SH_IR)
				ir_sh_ff <= {tdi_ff, ir_sh_ff[`SCP_IR_W-1:1]};
			if (tap_ff == TAP_UPD_IR)
				ir_ff <= ir_sh_ff;
			else if (tap_ff == TAP_RESET)
				ir_ff <= `SCP_IR_BYPASS;
			if (tap_ff == TAP_CAP_DR)
				byp_ff <= 1'b0;
			else if (tap_ff == TAP_SH_DR)
				byp_ff <= tdi_ff;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			tdo_ff <= 1'b1;
		else if (tck_fall)
			tdo_ff <= (tap_ff == TAP_SH_IR) ? ir_sh_ff[0] : byp_ff;
	end
	assign tdo = tdo_ff;

	// reload pulse on config instruction update
	logic [$clog2(PULSE_CYC+1)-1:0] pulse_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			pulse_ff <= '0;
		else if (tck_rise && tap_ff == TAP_UPD_IR && ir_sh_ff == `SCP_IR_CONFIG)
			pulse_ff <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
		else if (pulse_ff != '0)
			pulse_ff <= pulse_ff - 1'b1;
	end
	assign fpga_reload_pulse_n_o    = 1'b0;
	assign fpga_reload_pulse_n_oe_n = pulse_ff == '0;

	logic jtag_idle;
	assign jtag_idle = tap_ff == TAP_RESET || tap_ff == TAP_IDLE;
	assign standby   = jtag_idle && ce_n_ff;
	assign serial_data_line_oe_n = !(oe_ff && !ce_n_ff && !last_ff
		&& !standby);

	a_data_off_ce: assert property (@(posedge clk_sys) disable iff (!rstn)
		ce_n_ff |-> serial_data_line_oe_n) else $error("data driven in standby");
	a_data_off_rst: assert property (@(posedge clk_sys) disable iff (!rstn)
		!oe_ff |-> serial_data_line_oe_n) else $error("data driven in reset");
	a_addr_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		!oe_ff |=> addr_ff == '0) else $error("address not cleared");
	a_addr_freeze: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ce_n_ff && oe_ff) |=> $stable(addr_ff)) else $error("address moved");
	a_addr_step: assert property (@(posedge clk_sys) disable iff (!rstn)
		(advance && !last_ff && oe_ff && addr_ff != {AW{1'b1}})
		|=> addr_ff == $past(addr_ff) + 1'b1) else $error("address step");
	a_data_last: assert property (@(posedge clk_sys) disable iff (!rstn)
		last_ff |-> serial_data_line_oe_n) else $error("data after last");
	sequence s_cfg_update;
		tck_rise && tap_ff == TAP_UPD_IR && ir_sh_ff == `SCP_IR_CONFIG;
	endsequence
	a_reload_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_cfg_update |=> !fpga_reload_pulse_n_oe_n [*8]) else $error("pulse");
	a_tap_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		!tck_rise |=> $stable(tap_ff)) else $error("tap moved off edge");
	a_cascade_set: assert property (@(posedge clk_sys) disable iff (!rstn)
		(last_ff && !lock_ff && oe_ff && !ce_n_ff)
		|=> (!cascade_enable_out_n || ce_n_ff)) else $error("cascade late");
	a_cascade_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
		lock_ff |-> cascade_enable_out_n) else $error("cascade after oe");
	a_tap_reset: assert property (@(posedge clk_sys)
		!rstn |=> tap_ff == TAP_RESET) else $error("tap not reset");
	a_tdo_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
		(tck_fall && tap_ff == TAP_SH_IR) |=> tdo == $past(ir_sh_ff[0]))
		else $error("tdo not shifted");
endmodule
`default_nettype wire

// File: include/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_IR_W        4
`define SCP_IR_BYPASS   4'hf
`define SCP_IR_CONFIG   4'he
`define SCP_IR_RESET    4'h1
`define SCP_FIFO_DEPTH  8
`define SCP_PULSE_NS    20000
`define SCP_CLK_NS      10
`define SCP_PULSE_CYC   (`SCP_PULSE_NS / `SCP_CLK_NS)
`endif

// File: include/scp_pkg.sv
package scp_pkg;
	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
		TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} scp_tap_e;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} scp_jtag_s;
	typedef struct packed {
		logic cclk;
		logic reset_oe;
		logic ce_n;
	} scp_cfg_s;
endpackage

// File: rtl/scp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module scp_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,  // system clock
	input  wire logic             rstn,     // sync reset, active low
	input  wire logic             flush,    // drop contents
	input  wire logic             in_valid, // write request
	output logic                  in_ready, // space available
	input  wire logic [WIDTH-1:0] in_data,  // write data
	output logic                  out_valid,// data available
	input  wire logic             out_ready,// read accept
	output logic      [WIDTH-1:0] out_data  // read data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_ff;
	logic [AW:0]      rp_ff;
	assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
	assign out_valid = wp_ff != rp_ff;
	assign out_data  = mem[rp_ff[AW-1:0]];
	always_ff @(posedge clk_sys) begin
		if (!rstn || flush)
			wp_ff <= '0;
		else if (in_valid && in_ready)
			wp_ff <= wp_ff + 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready)
			mem[wp_ff[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn || flush)
			rp_ff <= '0;
		else if (out_valid && out_ready)
			rp_ff <= rp_ff + 1'b1;
	end
endmodule
`default_nettype wire

// File: verif/scp_fpga_model.sv
`timescale 1ns/1ns
`default_nettype none
module scp_fpga_model (
	input  wire logic            clk_sys,   // system clock
	input  wire logic            data_line, // resolved data line
	output var scp_pkg::scp_cfg_s cfg,      // cclk, reset_oe, ce_n
	output var logic             rx_valid,  // one bit taken
	output var logic             rx_bit     // taken bit
);
	import scp_pkg::*;
	initial begin
		cfg = '{cclk: 1'b0, reset_oe: 1'b1, ce_n: 1'b1};
		rx_valid = 1'b0;
		rx_bit = 1'b0;
	end
	// levels change just after an edge and stay long past sync latency
	task automatic set_ctl(input logic oe, input logic ce_n);
		@(posedge clk_sys);
		cfg.reset_oe <= oe;
		cfg.ce_n <= ce_n;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask
	// cclk runs for n bits, data sampled at each rise and marked taken only when take is set
	task automatic clock_bits(input int n, input logic take);
		repeat (n) begin
			@(posedge clk_sys);
			cfg.cclk <= 1'b1;
			rx_valid <= take;
			rx_bit <= data_line;
			@(posedge clk_sys);
			rx_valid <= 1'b0;
			repeat (4) @(posedge clk_sys);
			cfg.cclk <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		#1;
	endtask
endmodule
`default_nettype wire

// File: verif/serial_config_prom_readout_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "scp_defs.svh"
module serial_config_prom_readout_bench;
	import scp_pkg::*;
	localparam int AW = 4;
	localparam int PCYC = 10;
	localparam logic [10:0] TMS_SEQ = 11'h306;
	localparam logic [3:0]  IR_CFG  = `SCP_IR_CONFIG;
	localparam logic [3:0]  IR_CAP  = `SCP_IR_RESET;
	logic clk_sys, rstn, mem_bit, d_o, d_oe_n, ceo_n, rl_o, rl_oe_n, tdo;
	logic standby, rx_valid, rx_bit, data_line, so;
	logic [AW-1:0] mem_addr;
	logic [15:0] rom;
	logic [31:0] rnd;
	scp_jtag_s jtag;
	scp_cfg_s cfg;
	logic exp_q[$];
	int n_mismatch, comparisons, low_cnt, i;
	function automatic logic [31:0] lfsr_nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	assign mem_bit = rom[mem_addr];
	assign data_line = d_oe_n ? 1'b1 : d_o;
	scp_readout #(.AW(AW), .PULSE_CYC(PCYC)) DUT (.clk_sys(clk_sys),
		.rstn(rstn), .cfg_pins(cfg), .jtag_pins(jtag),
		.serial_data_line_o(d_o), .serial_data_line_oe_n(d_oe_n),
		.cascade_enable_out_n(ceo_n), .fpga_reload_pulse_n_o(rl_o),
		.fpga_reload_pulse_n_oe_n(rl_oe_n), .tdo(tdo),
		.standby(standby), .mem_addr(mem_addr), .mem_bit(mem_bit));
	scp_fpga_model FPGA (.clk_sys(clk_sys), .data_line(data_line),
		.cfg(cfg), .rx_valid(rx_valid), .rx_bit(rx_bit));
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t bit got %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t value got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// tms and tdi are set while tck is low, tdo taken just before the rise
	task automatic jstep(input logic tms, input logic tdi, output logic s);
		@(posedge clk_sys);
		jtag.tck <= 1'b0;
		jtag.tms <= tms;
		jtag.tdi <= tdi;
		repeat (10) @(posedge clk_sys);
		#1 s = tdo;
		@(posedge clk_sys);
		jtag.tck <= 1'b1;
		repeat (9) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		end_sim;
	end
	always @(posedge clk_sys) begin
		if (rl_oe_n === 1'b0 && rl_o === 1'b0)
			low_cnt++;
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk_bit(1'bx, rx_bit);
			else
				chk_bit(rx_bit, exp_q.pop_front());
		end
	end
	initial begin
		n_mismatch = 0;
		comparisons = 0;
		low_cnt = 0;
		rstn = 1'b0;
		jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
		rnd = 32'hc97f;
		for (i = 0; i < 16; i++) begin
			rnd = lfsr_nx(rnd);
			rom[i] = rnd[0];
		end
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk_bit(d_oe_n, 1'b1);
		chk_bit(ceo_n, 1'b1);
		chk_val(8'(mem_addr), 8'h00);
		chk_bit(tdo, 1'b1);
		$display("test reset state done");
		FPGA.set_ctl(1'b1, 1'b0);
		chk_bit(d_oe_n, 1'b0);
		chk_bit(standby, 1'b0);
		for (i = 0; i < 16; i++)
			exp_q.push_back(rom[i]);
		FPGA.clock_bits(16, 1'b1);
		chk_bit(ceo_n, 1'b0);
		chk_bit(d_oe_n, 1'b1);
		FPGA.clock_bits(3, 1'b0);
		chk_bit(ceo_n, 1'b0);
		FPGA.set_ctl(1'b1, 1'b1);
		chk_bit(ceo_n, 1'b1);
		chk_bit(standby, 1'b1);
		chk_bit(d_oe_n, 1'b1);
		FPGA.set_ctl(1'b1, 1'b0);
		chk_bit(ceo_n, 1'b0);
		$display("test full read and cascade done");
		FPGA.set_ctl(1'b0, 1'b0);
		chk_val(8'(mem_addr), 8'h00);
		chk_bit(ceo_n, 1'b1);
		chk_bit(d_oe_n, 1'b1);
		FPGA.set_ctl(1'b1, 1'b0);
		for (i = 0; i < 5; i++)
			exp_q.push_back(rom[i]);
		FPGA.clock_bits(5, 1'b1);
		chk_bit(ceo_n, 1'b1);
		FPGA.set_ctl(1'b1, 1'b1);
		FPGA.clock_bits(4, 1'b0);
		chk_val(8'(mem_addr), 8'h05);
		chk_bit(d_oe_n, 1'b1);
		FPGA.set_ctl(1'b0, 1'b1);
		FPGA.set_ctl(1'b1, 1'b1);
		chk_val(8'(mem_addr), 8'h00);
		chk_bit(d_oe_n, 1'b1);
		$display("test counter reset and standby done");
		chk_val(8'(low_cnt), 8'h00);
		// idle, select ir, capture, shift four bits, update, idle
		for (i = 0; i < 11; i++) begin
			rnd = lfsr_nx(rnd);
			if (i >= 5 && i <= 8) begin
				jstep(TMS_SEQ[i], IR_CFG[i-5], so);
				chk_bit(so, IR_CAP[i-5]);
			end else
				jstep(TMS_SEQ[i], rnd[0], so);
		end
		repeat (40) @(posedge clk_sys);
		chk_val(8'(low_cnt), 8'(PCYC));
		$display("test scan reload pulse done");
		// full read again through the buffered data path
		FPGA.set_ctl(1'b1, 1'b0);
		chk_bit(d_oe_n, 1'b0);
		for (i = 0; i < 16; i++)
			exp_q.push_back(rom[i]);
		FPGA.clock_bits(16, 1'b1);
		chk_val(8'(mem_addr), 8'h0f);
		chk_bit(ceo_n, 1'b0);
		chk_bit(d_oe_n, 1'b1);
		chk_val(8'(exp_q.size()), 8'h00);
		$display("test buffered re-read done");
		end_sim;
	end
endmodule
`default_nettype wire
